//--- design/serial_channel.sv
/*
  one serial channel used as a clocked-serial slave, with its mode and
  control registers on axi4-lite and two level interrupts, chan_irq and irq_out.
  assumes the master drives sck, cs_n and mosi asynchronously to aclk.
*/
// What this block does
// - parity field selects none, zero, even, odd
// - bit order bit picks msb or lsb first
// - stop field gives zero to three bits
// - csi character is seven or eight bits
// - op clock from prescaler output a or b
// - transfer clock divided op clock or sck pin
// - start by software or receive pin edge
// - receive inversion picks falling or rising start
// - mode field selects csi, uart, i2c
// - irq on transfer end or buffer empty
// - pending flag set by event, cleared by software
// - mask bit blocks channel interrupt when set
// - start write sets enable, enters wait state
// - error irq enable gates parity error event
`timescale 1ns/100ps
`include "serial_channel_consts.svh"
module serial_channel
  import serial_channel_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              sck_in,
  input  wire logic              cs_n_in,
  input  wire logic              mosi_in,
  output logic                   miso_out,
  output logic                   miso_oe,
  output logic                   chan_irq,
  output logic                   irq_out
);
  logic [7:0]        comm_op_high_reg;
  logic [7:0]        comm_op_low_reg;
  logic [7:0]        channel_mode_high_reg;
  logic [7:0]        channel_mode_low_reg;
  logic              chan_irq_pending_reg;
  logic              chan_irq_block_reg;
  logic              chan_op_enabled_reg;
  logic [7:0]        prescaler_setting_reg;
  logic [7:0]        tx_data_reg;
  logic [7:0]        rx_data_reg;
  logic              tx_full_reg;
  logic [`EV_W-1:0]  evt_status_reg;
  logic [`EV_W-1:0]  evt_enable_reg;
  logic [`EV_W-1:0]  evt_set;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic              aw_have_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              w_have_reg;
  logic              wr_fire;
  logic              wr_hit;
  logic [7:0]        wbyte;
  logic              sck_level;
  logic              sck_rise;
  logic              sck_fall;
  logic              cs_meta_reg;
  logic              cs_sync_reg;
  logic              cs_last_reg;
  logic              cs_fall;
  logic              xfer_start;
  logic [7:0]        tx_ordered;
  logic              rx_meta_reg;
  logic              rx_sync_reg;
  logic              rx_last_reg;
  logic [7:0]        pre_cnt_reg;
  logic              prescaler_out_a;
  logic              prescaler_out_b;
  logic              channel_op_clock;
  logic              transfer_clock;
  logic              start_edge;
  xfer_state_type    xfer_state_reg;
  logic [7:0]        shift_out_reg;
  logic [7:0]        shift_in_reg;
  logic [3:0]        bit_cnt_reg;
  logic              parity_acc_reg;
  logic              xfer_done;
  logic              parity_err;
  logic              sample_edge;
  logic              drive_edge;
  chan_mode_type     chan_mode;
  logic [1:0]        parity_sel;
  logic [1:0]        stop_len;
  logic [3:0]        char_len;

  // msb-first or lsb-first slot of a byte
  function automatic logic [7:0] order_byte(input logic [7:0] d, input logic lsb_first);
    logic [7:0] r;
    r = d;
    if (lsb_first) begin
      for (int i = 0; i < 8; i++) begin
        r[i] = d[7-i];
      end
    end
    return r;
  endfunction

  assign chan_mode  = chan_mode_type'({channel_mode_low_reg[`B_MODE_HI],
                                       channel_mode_low_reg[`B_MODE_LO]});
  assign parity_sel = {comm_op_high_reg[`B_PARITY_HI], comm_op_high_reg[`B_PARITY_LO]};
  assign stop_len   = {comm_op_low_reg[`B_STOP_HI], comm_op_low_reg[`B_STOP_LO]};
  assign char_len   = comm_op_low_reg[`B_CHAR_LEN] ? `CHAR_LEN_LONG : `CHAR_LEN_SHORT;

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write path
  assign wr_fire = aw_have_reg & w_have_reg & ~s_axi_bvalid;
  assign wbyte   = w_strb_reg[0] ? w_data_reg[7:0] : 8'h00;
  assign wr_hit  = wr_fire & w_strb_reg[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      aw_addr_reg   <= '0;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_have_reg & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_have_reg & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_reg > `OFS_PRESCALE || aw_addr_reg[1:0] != 2'b00)
                        ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      comm_op_high_reg      <= `RST_COMM_OP_HIGH;
      comm_op_low_reg       <= `RST_COMM_OP_LOW;
      channel_mode_high_reg <= `RST_CHAN_MODE_HIGH;
      channel_mode_low_reg  <= `RST_CHAN_MODE_LOW;
      chan_irq_block_reg    <= 1'b1;
      prescaler_setting_reg <= `RST_PRESCALE;
      evt_enable_reg        <= '0;
    end else if (wr_hit) begin
      unique case (aw_addr_reg)
        `OFS_COMM_OP_HIGH:   comm_op_high_reg      <= wbyte;
        `OFS_COMM_OP_LOW:    comm_op_low_reg       <= wbyte;
        `OFS_CHAN_MODE_HIGH: channel_mode_high_reg <= wbyte;
        `OFS_CHAN_MODE_LOW:  channel_mode_low_reg  <= wbyte;
        `OFS_IRQ_MASK_LOW:   chan_irq_block_reg    <= wbyte[`B_CHAN_IRQ];
        `OFS_PRESCALE:       prescaler_setting_reg <= wbyte;
        `OFS_EVT_ENABLE:     evt_enable_reg        <= wbyte[`EV_W-1:0];
        default: ;
      endcase
    end
  end

  // start sets the enable, stop clears it; writing zero does nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_op_enabled_reg <= 1'b0;
    end else if (wr_hit && aw_addr_reg == `OFS_START_TRIG && wbyte[0]) begin
      chan_op_enabled_reg <= 1'b1;
    end else if (wr_hit && aw_addr_reg == `OFS_STOP_TRIG && wbyte[0]) begin
      chan_op_enabled_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        unique case (s_axi_araddr)
          `OFS_COMM_OP_HIGH:   s_axi_rdata <= {24'h00_0000, comm_op_high_reg};
          `OFS_COMM_OP_LOW:    s_axi_rdata <= {24'h00_0000, comm_op_low_reg};
          `OFS_CHAN_MODE_HIGH: s_axi_rdata <= {24'h00_0000, channel_mode_high_reg};
          `OFS_CHAN_MODE_LOW:  s_axi_rdata <= {24'h00_0000, channel_mode_low_reg};
          `OFS_IRQ_REQ_LOW:    s_axi_rdata <= {28'h000_0000, chan_irq_pending_reg, 3'b000};
          `OFS_IRQ_MASK_LOW:   s_axi_rdata <= {28'h000_0000, chan_irq_block_reg, 3'b000};
          `OFS_START_TRIG:     s_axi_rdata <= {31'h0000_0000, chan_op_enabled_reg};
          `OFS_TX_DATA:        s_axi_rdata <= {23'h00_0000, tx_full_reg, tx_data_reg};
          `OFS_RX_DATA:        s_axi_rdata <= {24'h00_0000, rx_data_reg};
          `OFS_EVT_STATUS:     s_axi_rdata <= {29'h0000_0000, evt_status_reg};
          `OFS_EVT_ENABLE:     s_axi_rdata <= {29'h0000_0000, evt_enable_reg};
          `OFS_PRESCALE:       s_axi_rdata <= {24'h00_0000, prescaler_setting_reg};
          `OFS_STOP_TRIG, `OFS_EVT_CLEAR: s_axi_rdata <= 32'h0000_0000;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescaler and clock selection, all as enables on aclk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_cnt_reg <= 8'h00;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 8'h01;
    end
  end
  // output a runs every four cycles, output b once per 256 cycles when the count equals the setting
  assign prescaler_out_a  = (pre_cnt_reg[1:0] == 2'b11);
  assign prescaler_out_b  = (pre_cnt_reg == prescaler_setting_reg);
  assign channel_op_clock = channel_mode_high_reg[`B_OP_CLK_SEL]
                            ? prescaler_out_b : prescaler_out_a;

  sck_edge_sync sck_sync_u (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin_in    (sck_in),
    .level_out (sck_level),
    .rise_out  (sck_rise),
    .fall_out  (sck_fall)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cs_meta_reg <= 1'b1;
      cs_sync_reg <= 1'b1;
      cs_last_reg <= 1'b1;
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      rx_last_reg <= 1'b1;
    end else begin
      cs_meta_reg <= cs_n_in;
      cs_sync_reg <= cs_meta_reg;
      cs_last_reg <= cs_sync_reg;
      rx_meta_reg <= mosi_in;
      rx_sync_reg <= rx_meta_reg;
      rx_last_reg <= rx_sync_reg;
    end
  end

  // external clock: sample on rise, drive on fall; internal: op clock ticks, sample while synced sck is high, drive while low
  assign transfer_clock = channel_mode_high_reg[`B_XFER_CLK] ? sck_rise
                                                             : channel_op_clock;
  assign sample_edge = channel_mode_high_reg[`B_XFER_CLK] ? sck_rise
                       : (channel_op_clock & sck_level);
  assign drive_edge  = channel_mode_high_reg[`B_XFER_CLK] ? sck_fall
                       : (channel_op_clock & ~sck_level);
  // start bit edge, polarity chosen by the inversion bit
  assign start_edge = channel_mode_low_reg[`B_RX_INVERT]
                      ? (rx_sync_reg & ~rx_last_reg)
                      : (~rx_sync_reg & rx_last_reg);
  assign cs_fall    = ~cs_sync_reg & cs_last_reg;
  assign tx_ordered = order_byte(tx_data_reg, comm_op_low_reg[`B_BIT_ORDER]);
  // wait state: software trigger, or receive edge when selected; a slave
  // under software start waits for a fresh cs_n fall, so an open frame never restarts
  assign xfer_start = (xfer_state_reg == xfer_idle) & chan_op_enabled_reg &
                      (channel_mode_high_reg[`B_START_SRC] ? start_edge
                       : (channel_mode_high_reg[`B_XFER_CLK] ? cs_fall : 1'b1));

  ////////////////////////////////////////////////////////////////////////////
  // shifter; in slave mode cs_n frames the character
  assign xfer_done  = (xfer_state_reg == xfer_shift) & sample_edge & (bit_cnt_reg == 4'h1);
  // parity check on the last received bit for even and odd only
  assign parity_err = xfer_done & parity_sel[1] & (chan_mode == mode_uart_type_v) &
                      (parity_acc_reg ^ rx_sync_reg ^ parity_sel[0]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xfer_state_reg <= xfer_idle;
      shift_out_reg  <= 8'h00;
      shift_in_reg   <= 8'h00;
      bit_cnt_reg    <= 4'h0;
      parity_acc_reg <= 1'b0;
      rx_data_reg    <= 8'h00;
      tx_full_reg    <= 1'b0;
      tx_data_reg    <= 8'h00;
      miso_out       <= 1'b1;
      miso_oe        <= 1'b0;
    end else begin
      if (wr_hit && aw_addr_reg == `OFS_TX_DATA) begin
        tx_data_reg <= wbyte;
        tx_full_reg <= 1'b1;
      end
      miso_oe <= chan_op_enabled_reg & comm_op_high_reg[`B_TX_EN] & ~cs_sync_reg;
      unique case (xfer_state_reg)
        xfer_idle: begin
          if (xfer_start) begin
            xfer_state_reg <= xfer_shift;
            shift_out_reg  <= tx_ordered;
            tx_full_reg    <= 1'b0;
            bit_cnt_reg    <= char_len + ((chan_mode == mode_uart_type_v)
                              ? {2'b00, stop_len} + {3'b000, (parity_sel != 2'b00)}
                              : 4'h0);
            parity_acc_reg <= 1'b0;
            miso_out       <= tx_ordered[7];
          end
        end
        xfer_shift: begin
          // a frame cut short by cs_n rising is dropped, not resumed later
          if (!chan_op_enabled_reg || (channel_mode_high_reg[`B_XFER_CLK] && cs_sync_reg)) begin
            xfer_state_reg <= xfer_idle;
          end else if (sample_edge) begin
            shift_in_reg   <= {shift_in_reg[6:0], rx_sync_reg};
            parity_acc_reg <= parity_acc_reg ^ rx_sync_reg;
            bit_cnt_reg    <= bit_cnt_reg - 4'h1;
            if (bit_cnt_reg == 4'h1) begin
              xfer_state_reg <= xfer_idle;
              rx_data_reg    <= order_byte({shift_in_reg[6:0], rx_sync_reg},
                                           comm_op_low_reg[`B_BIT_ORDER]);
            end
          end else if (drive_edge) begin
            shift_out_reg <= {shift_out_reg[6:0], 1'b0};
            miso_out      <= shift_out_reg[6];
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // events and interrupts; a set in the clearing cycle wins
  assign evt_set[`EV_XFER_END]   = xfer_done;
  // loading the buffered character into the shifter empties the buffer
  assign evt_set[`EV_BUF_EMPTY]  = xfer_start & tx_full_reg;
  assign evt_set[`EV_PARITY_ERR] = parity_err & comm_op_high_reg[`B_ERR_IRQ_EN];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_status_reg <= '0;
    end else begin
      evt_status_reg <= (evt_status_reg &
                         ~((wr_hit && aw_addr_reg == `OFS_EVT_CLEAR) ? wbyte[`EV_W-1:0] : '0))
                        | evt_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_irq_pending_reg <= 1'b0;
    end else if (channel_mode_low_reg[`B_IRQ_SRC] ? evt_set[`EV_BUF_EMPTY]
                                                  : evt_set[`EV_XFER_END]) begin
      chan_irq_pending_reg <= 1'b1;
    end else if (wr_hit && aw_addr_reg == `OFS_IRQ_REQ_LOW && !wbyte[`B_CHAN_IRQ]) begin
      chan_irq_pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_irq <= 1'b0;
      irq_out  <= 1'b0;
    end else begin
      chan_irq <= chan_irq_pending_reg & ~chan_irq_block_reg;
      irq_out  <= |(evt_status_reg & evt_enable_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  pending_irq_masked_a: assert property (@(posedge aclk) disable iff (!aresetn)
    chan_irq_block_reg |=> !chan_irq) else $error("irq passed the mask");
  start_sets_enable_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_hit && aw_addr_reg == `OFS_START_TRIG && wbyte[0]) |=> chan_op_enabled_reg)
    else $error("start did not enable");
  done_sets_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (xfer_done && !channel_mode_low_reg[`B_IRQ_SRC]) |=> chan_irq_pending_reg)
    else $error("transfer end lost");
  err_gated_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !comm_op_high_reg[`B_ERR_IRQ_EN] |-> !evt_set[`EV_PARITY_ERR])
    else $error("error event not masked");
  char_length_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (xfer_start && chan_mode == mode_csi_type_v) |=> (bit_cnt_reg ==
    ($past(comm_op_low_reg[`B_CHAR_LEN]) ? `CHAR_LEN_LONG : `CHAR_LEN_SHORT)))
    else $error("csi length wrong");
  one_bit_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (xfer_state_reg == xfer_shift && chan_op_enabled_reg && !cs_sync_reg && sample_edge)
    |=> (bit_cnt_reg == $past(bit_cnt_reg) - 4'h1)) else $error("bit count skipped");
endmodule

//--- design/serial_channel_consts.svh
`ifndef SERIAL_CHANNEL_CONSTS_SVH
`define SERIAL_CHANNEL_CONSTS_SVH
// register byte offsets
`define OFS_COMM_OP_HIGH     8'h00
`define OFS_COMM_OP_LOW      8'h04
`define OFS_CHAN_MODE_HIGH   8'h08
`define OFS_CHAN_MODE_LOW    8'h0C
`define OFS_IRQ_REQ_LOW      8'h10
`define OFS_IRQ_MASK_LOW     8'h14
`define OFS_START_TRIG       8'h18
`define OFS_STOP_TRIG        8'h1C
`define OFS_TX_DATA          8'h20
`define OFS_RX_DATA          8'h24
`define OFS_EVT_STATUS       8'h28
`define OFS_EVT_CLEAR        8'h2C
`define OFS_EVT_ENABLE       8'h30
`define OFS_PRESCALE         8'h34
// field positions
`define B_TX_EN        7
`define B_RX_EN        6
`define B_ERR_IRQ_EN   2
`define B_PARITY_HI    1
`define B_PARITY_LO    0
`define B_BIT_ORDER    7
`define B_STOP_HI      5
`define B_STOP_LO      4
`define B_CHAR_LEN     0
`define B_OP_CLK_SEL   7
`define B_XFER_CLK     6
`define B_START_SRC    0
`define B_RX_INVERT    6
`define B_MODE_HI      2
`define B_MODE_LO      1
`define B_IRQ_SRC      0
`define B_CHAN_IRQ     3
// reset values
`define RST_COMM_OP_HIGH   8'h00
`define RST_COMM_OP_LOW    8'h07
`define RST_CHAN_MODE_HIGH 8'h00
`define RST_CHAN_MODE_LOW  8'h20
`define RST_IRQ_MASK_LOW   8'h08
`define RST_PRESCALE       8'h10
// event bits
`define EV_XFER_END   0
`define EV_BUF_EMPTY  1
`define EV_PARITY_ERR 2
`define EV_W          3
// axi responses
`define RESP_OKAY   2'b00
`define RESP_SLVERR 2'b10
`define CHAR_LEN_SHORT 4'h7
`define CHAR_LEN_LONG  4'h8
`endif

//--- design/serial_channel_pkg.sv
/*
  types shared by the serial channel design.
  assumes the constants header is compiled alongside.
*/
package serial_channel_pkg;
  typedef enum logic [1:0] {mode_csi_type_v, mode_uart_type_v, mode_i2c_type_v,
                            mode_bad_type_v} chan_mode_type;
  typedef enum logic {xfer_idle, xfer_shift} xfer_state_type;
endpackage

//--- design/sck_edge_sync.sv
/*
  two-flop synchroniser for one pin, with rise and fall pulses taken
  from the second and third stages.
  assumes the pin is asynchronous to aclk.
*/
`timescale 1ns/100ps
module sck_edge_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin_in,
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
      rise_out <= 1'b0;
      fall_out <= 1'b0;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
      rise_out <= sync_reg & ~last_reg;
      fall_out <= ~sync_reg & last_reg;
    end
  end
  assign level_out = last_reg;
endmodule

//--- bench/spi_master_model.sv
/*
  behavioural clocked-serial master: frames with cs_n low, drives mosi
  msb first, samples miso on the rising sck edge.
  assumes the slave samples on the sck rise and drives on the fall.
*/
`timescale 1ns/100ps
module spi_master_model (
  input  wire logic aclk,
  input  wire logic miso,
  input  wire logic miso_oe,
  output logic      sck,
  output logic      cs_n,
  output logic      mosi
);
  // half period in aclk cycles, long enough for the two-flop synchroniser
  localparam int HALF = 6;
  initial begin
    sck  = 1'h0;
    cs_n = 1'h1;
    mosi = 1'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic frame(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    cs_n <= 1'h0;
    for (int i = 0; i < nb; i++) begin
      mosi <= tx[nb-1-i];
      repeat (HALF) @(posedge aclk);
      // a released miso reads as unknown so the compare catches it
      rx = {rx[6:0], (miso_oe === 1'h1) ? miso : 1'hx};
      sck <= 1'h1;
      repeat (HALF) @(posedge aclk);
      sck <= 1'h0;
    end
    repeat (HALF) @(posedge aclk);
    cs_n <= 1'h1;
    // no pull on mosi: leave it at the opposite of the last bit
    mosi <= ~tx[0];
  endtask
endmodule

//--- bench/serial_channel_tb.sv
/*
  self-checking bench for serial_channel: register access over axi4-lite,
  interrupts, and slave transfers against the master model.
  assumes the design files and the master model are compiled first.
*/
`timescale 1ns/100ps
`include "serial_channel_consts.svh"
module serial_channel_tb;
  logic        aclk;
  logic        aresetn;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        sck;
  logic        cs_n;
  logic        mosi;
  logic        miso;
  logic        miso_oe;
  logic        chan_irq;
  logic        irq_out;
  int          bad_count;
  int          checks;
  logic [31:0] rd;
  logic [1:0]  rs;
  logic [7:0]  got;
  // address in the high byte, written and read-back value in the low byte
  logic [15:0] tbl [14] = '{16'h0003, 16'h0002, 16'h0001, 16'h0000, 16'h0004,
    16'h0410, 16'h0420, 16'h0480, 16'h0881, 16'h0840, 16'h0C40, 16'h0C02,
    16'h0C04, 16'h0C01};
  serial_channel serial_channel_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'h1), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'h1), .sck_in(sck),
    .cs_n_in(cs_n), .mosi_in(mosi), .miso_out(miso), .miso_oe(miso_oe),
    .chan_irq(chan_irq), .irq_out(irq_out));
  spi_master_model spi_master_model_inst (
    .aclk(aclk), .miso(miso), .miso_oe(miso_oe), .sck(sck), .cs_n(cs_n), .mosi(mosi));
  initial begin
    aclk = 1'h0;
    forever #2 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkb(input string nm, input logic e, input logic g);
    chk(nm, {31'h0000_0000, e}, {31'h0000_0000, g});
  endtask
  // bready and rready stay high, so the answer is taken at the edge it is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    rs = bresp;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    araddr  <= a;
    arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rd = rdata;
    rs = rresp;
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd_reg(a);
    chk(nm, e, rd);
  endtask
  task automatic xfer(input logic [7:0] lo, input logic [7:0] ml, input logic [7:0] tx,
                      input logic [7:0] m, input int nb, input logic [7:0] er,
                      input logic [7:0] em);
    wr(`OFS_IRQ_REQ_LOW, 32'h0000_0000);
    wr(`OFS_EVT_CLEAR, 32'h0000_0007);
    wr(`OFS_COMM_OP_LOW, {24'h00_0000, lo});
    wr(`OFS_CHAN_MODE_LOW, {24'h00_0000, ml});
    if (nb == 8) wr(`OFS_TX_DATA, {24'h00_0000, tx});
    spi_master_model_inst.frame(m, nb, got);
    do rd_reg(`OFS_EVT_STATUS);
    while (rd[`EV_XFER_END] !== 1'h1);
    if (nb == 8) begin
      rc("rx data", `OFS_RX_DATA, {24'h00_0000, er});
      chk("miso bits", {24'h00_0000, em}, {24'h00_0000, got});
    end
  endtask
  task automatic close_out();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    bad_count++;
    close_out();
  end
  initial begin
    {aresetn, awaddr, awvalid, wdata, wvalid, araddr, arvalid} = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rc("op high", `OFS_COMM_OP_HIGH, `RST_COMM_OP_HIGH);
    rc("op low", `OFS_COMM_OP_LOW, `RST_COMM_OP_LOW);
    rc("mode high", `OFS_CHAN_MODE_HIGH, `RST_CHAN_MODE_HIGH);
    rc("mode low", `OFS_CHAN_MODE_LOW, `RST_CHAN_MODE_LOW);
    rc("mask", `OFS_IRQ_MASK_LOW, `RST_IRQ_MASK_LOW);
    rc("unmapped", 8'h3C, 32'h0000_0000);
    chk("rresp", `RESP_SLVERR, rs);
    wr(8'h40, 32'h0000_0001);
    chk("bresp", `RESP_SLVERR, rs);
    for (int i = 0; i < 14; i++) begin
      wr(tbl[i][15:8], {24'h00_0000, tbl[i][7:0]});
      rc("field", tbl[i][15:8], {24'h00_0000, tbl[i][7:0]});
    end
    wr(`OFS_COMM_OP_HIGH, 32'h0000_00C0);
    wr(`OFS_CHAN_MODE_HIGH, 32'h0000_0040);
    rc("start", `OFS_START_TRIG, 32'h0000_0000);
    wr(`OFS_START_TRIG, 32'h0000_0000);
    rc("start", `OFS_START_TRIG, 32'h0000_0000);
    wr(`OFS_START_TRIG, 32'h0000_0001);
    rc("start", `OFS_START_TRIG, 32'h0000_0001);
    xfer(8'h07, 8'h20, 8'hA5, 8'h3C, 8, 8'h3C, 8'hA5);
    rc("pending", `OFS_IRQ_REQ_LOW, 32'h0000_0008);
    chkb("chan_irq", 1'h0, chan_irq);
    wr(`OFS_IRQ_MASK_LOW, 32'h0000_0000);
    repeat (2) @(posedge aclk);
    chkb("chan_irq", 1'h1, chan_irq);
    wr(`OFS_IRQ_REQ_LOW, 32'h0000_0000);
    repeat (2) @(posedge aclk);
    chkb("chan_irq", 1'h0, chan_irq);
    chkb("irq_out", 1'h0, irq_out);
    wr(`OFS_EVT_ENABLE, 32'h0000_0001);
    repeat (2) @(posedge aclk);
    chkb("irq_out", 1'h1, irq_out);
    wr(`OFS_EVT_CLEAR, 32'h0000_0001);
    repeat (2) @(posedge aclk);
    chkb("irq_out", 1'h0, irq_out);
    xfer(8'h87, 8'h20, 8'h96, 8'h35, 8, 8'hAC, 8'h69);
    // seven-bit frame, buffer-empty source and nothing loaded: no request
    xfer(8'h06, 8'h21, 8'h00, 8'h55, 7, 8'h00, 8'h00);
    rc("pending", `OFS_IRQ_REQ_LOW, 32'h0000_0000);
    // uart, seven data bits and even parity, parity bit sent wrong
    wr(`OFS_COMM_OP_HIGH, 32'h0000_00C6);
    wr(`OFS_CHAN_MODE_LOW, 32'h0000_0022);
    wr(`OFS_EVT_CLEAR, 32'h0000_0007);
    spi_master_model_inst.frame(8'h02, 8, got);
    rc("parity err", `OFS_EVT_STATUS, 32'h0000_0005);
    close_out();
  end
endmodule
